// File: common/rfph_pkg.sv
// Shared constants and types for the radio FIFO packet handler
package rfph_pkg;

	// ****************************************
	// Queues and host commands
	// ****************************************
	localparam int         FIFO_DEPTH  = 64;
	localparam int         CNT_W       = $clog2(FIFO_DEPTH + 1);
	localparam logic [7:0] CMD_TX_LOAD = 8'h66;
	localparam logic [7:0] CMD_RX_READ = 8'h77;
	localparam int         CLR_TX      = 0;
	localparam int         CLR_RX      = 1;

	// ****************************************
	// Frame coding
	// ****************************************
	localparam logic [7:0]  PRE_PATTERN = 8'haa;
	localparam logic [15:0] CRC_INIT    = 16'hffff;
	localparam logic [15:0] CRC_POLY    = 16'h1021;
	localparam logic [8:0]  PN9_SEED    = 9'h1ff;
	localparam int          PN9_TAP     = 5;
	localparam logic [3:0]  BYTE_BITS   = 4'h8;

	// ****************************************
	// Interrupt flag positions and reset values
	// ****************************************
	localparam int   IRQ_W       = 7;
	localparam int   IRQ_TX_AE   = 0;
	localparam int   IRQ_TX_DONE = 1;
	localparam int   IRQ_RX_AF   = 2;
	localparam int   IRQ_PRE     = 3;
	localparam int   IRQ_SYNC    = 4;
	localparam int   IRQ_PKT     = 5;
	localparam int   IRQ_CRC     = 6;
	localparam logic IRQ_N_RST   = 1'b1;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic pre;
		logic sync;
		logic hdr;
		logic len;
		logic crc;
	} rfph_fld_t;

	typedef struct packed {
		logic             ph_tx_en;
		logic             ph_rx_en;
		rfph_fld_t        fld;
		logic             whiten;
		logic             manch;
		logic [3:0]       pre_len;
		logic [5:0]       pre_thresh;
		logic [15:0]      sync_word;
		logic [7:0]       hdr;
		logic [7:0]       pay_len;
		logic [CNT_W-1:0] tx_ae_level;
		logic [CNT_W-1:0] rx_af_level;
	} rfph_cfg_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] code;
		logic [7:0] wdata;
	} rfph_cmd_t;

	typedef enum logic [7:0] {
		TX_IDLE = 8'h01,
		TX_PRE  = 8'h02,
		TX_SYNC = 8'h04,
		TX_HDR  = 8'h08,
		TX_LEN  = 8'h10,
		TX_DATA = 8'h20,
		TX_CRC  = 8'h40,
		TX_DONE = 8'h80
	} rfph_tx_st_t;

	typedef enum logic [6:0] {
		RX_OFF  = 7'h01,
		RX_PRE  = 7'h02,
		RX_SYNC = 7'h04,
		RX_HDR  = 7'h08,
		RX_LEN  = 7'h10,
		RX_DATA = 7'h20,
		RX_CRC  = 7'h40
	} rfph_rx_st_t;

endpackage

// File: src/rfph_fifo.sv
// Byte queue with synchronous clear, used for both directions
`timescale 1ns/1ps
module rfph_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = rfph_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic                       clk_sys_i,
	input  wire logic                       rst_n_i,
	// Write side
	input  wire logic                       clr_i,
	input  wire logic                       push_i,
	input  wire logic [WIDTH-1:0]           wdata_i,
	// Read side
	input  wire logic                       pop_i,
	output logic      [WIDTH-1:0]           rdata_o,
	output logic      [$clog2(DEPTH+1)-1:0] count_o,
	output logic                            full_o,
	output logic                            empty_o
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [AW-1:0] wptr;
		logic [AW-1:0] rptr;
		logic [CW-1:0] cnt;
	} rfph_fifo_st_t;

	rfph_fifo_st_t    q;
	rfph_fifo_st_t    d;
	logic [WIDTH-1:0] mem [DEPTH];
	logic             do_push;
	logic             do_pop;

	// Pointers wrap by width, so DEPTH must be a power of two
	assign do_push = push_i && !full_o && !clr_i;
	assign do_pop  = pop_i && !empty_o && !clr_i;
	assign rdata_o = mem[q.rptr];
	assign count_o = q.cnt;
	assign full_o  = (q.cnt == CW'(DEPTH));
	assign empty_o = (q.cnt == '0);

	always_comb begin
		d = q;
		if (clr_i) begin
			d = '0;
		end else begin
			if (do_push) begin
				d.wptr = q.wptr + AW'(1);
			end
			if (do_pop) begin
				d.rptr = q.rptr + AW'(1);
			end
			d.cnt = q.cnt + {{(CW-1){1'b0}}, do_push} - {{(CW-1){1'b0}}, do_pop};
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (do_push) begin
			mem[q.wptr] <= wdata_i;
		end
	end
endmodule

// File: src/rfph_crc16.sv
// Byte-wide CRC-16 update, MSB first
`timescale 1ns/1ps
module rfph_crc16 #(
	parameter logic [15:0] POLY = rfph_pkg::CRC_POLY
) (
	// Running value and next byte
	input  wire logic [15:0] crc_i,
	input  wire logic [7:0]  byte_i,
	output logic      [15:0] crc_o
);
	always_comb begin
		crc_o = crc_i;
		for (int i = 0; i < 8; i++) begin
			if (crc_o[15] ^ byte_i[7-i]) begin
				crc_o = {crc_o[14:0], 1'b0} ^ POLY;
			end else begin
				crc_o = {crc_o[14:0], 1'b0};
			end
		end
	end
endmodule

// File: src/rfph_top.sv
// Radio FIFO packet handler: host queues, frame builder and frame checker
`timescale 1ns/1ps
// How it works
// - Two independent 64-byte queues, one for transmit, one for receive.
// - Host command 66h appends its data byte to the transmit queue.
// - Host command 77h returns the oldest receive byte.
// - Transmit queue falling to its almost-empty level raises an event.
// - After the frame-sent event the transmitter returns to idle by itself.
// - Receive queue reaching its almost-full level raises an event on the low irq pin.
// - Almost-full means at least the level count of bytes can be read.
// - Clear command empties transmit, receive or both queues.
// - Framing is enabled separately for transmit and receive.
// - Preamble, sync, header, length and CRC each enable individually.
// - Receiver qualifies the preamble and pulses preamble-ok.
// - Receiver finds the sync word and pulses sync-found.
// - Receiver pulses frame-accepted when all enabled checks pass.
// - Receiver pulses checksum-mismatch when the CRC field differs.
// - Receiver removes whitening and Manchester coding when enabled.
// - Receiver compares the header byte and drops a mismatching frame.
// - Receiver writes data field bytes into the receive queue.
// - Transmitter generates preamble then sync itself.
// - Transmitter takes data bytes in order from the transmit queue.
// - Transmitter appends the computed CRC when enabled.
// - Transmitter applies whitening and Manchester coding when enabled.
module rfph_top (
	// Clock and reset
	input  wire logic                          clk_sys_i,
	input  wire logic                          rst_n_i,
	// Host command port
	input  wire rfph_pkg::rfph_cmd_t           cmd_i,
	input  wire logic [1:0]                    fifo_clr_i,
	output logic      [7:0]                    rd_data_o,
	output logic                               rd_valid_o,
	// Configuration
	input  wire rfph_pkg::rfph_cfg_t           cfg_i,
	input  wire logic                          tx_start_i,
	input  wire logic                          rx_on_i,
	// Modem transmit chips
	input  wire logic                          tx_chip_req_i,
	output logic                               tx_chip_o,
	output logic                               tx_chip_valid_o,
	output logic                               tx_busy_o,
	// Modem receive chips
	input  wire logic                          rx_chip_valid_i,
	input  wire logic                          rx_chip_i,
	// Status
	output logic                               pre_ok_o,
	output logic                               sync_found_o,
	output logic                               frame_accepted_o,
	output logic                               crc_mismatch_o,
	output logic                               tx_frame_done_event_o,
	output logic      [rfph_pkg::CNT_W-1:0]    tx_count_o,
	output logic      [rfph_pkg::CNT_W-1:0]    rx_count_o,
	// Interrupts
	input  wire logic [rfph_pkg::IRQ_W-1:0]    irq_en_i,
	input  wire logic [rfph_pkg::IRQ_W-1:0]    irq_ack_i,
	output logic      [rfph_pkg::IRQ_W-1:0]    irq_flags_o,
	output logic                               host_irq_n_o
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		rfph_pkg::rfph_tx_st_t        txs;
		logic [7:0]                   tsh;
		logic [3:0]                   tbits;
		logic                         thalf;
		logic                         twhit;
		logic [8:0]                   tpn;
		logic [7:0]                   tcnt;
		logic [15:0]                  tcrc;
		logic                         chip;
		logic                         chip_v;
		logic                         busy;
		rfph_pkg::rfph_rx_st_t        rxs;
		logic                         rhalf;
		logic                         rfirst;
		logic [15:0]                  rsr;
		logic [5:0]                   rprecnt;
		logic [7:0]                   rbyte;
		logic [2:0]                   rbits;
		logic                         rwhit;
		logic [8:0]                   rpn;
		logic [7:0]                   rcnt;
		logic [7:0]                   rlen;
		logic [15:0]                  rcrc;
		logic [7:0]                   rchi;
		logic [7:0]                   rd_data;
		logic                         rd_v;
		logic [rfph_pkg::CNT_W-1:0]   txc_prev;
		logic [rfph_pkg::CNT_W-1:0]   rxc_prev;
		logic [rfph_pkg::IRQ_W-1:0]   ev;
		logic [rfph_pkg::IRQ_W-1:0]   irq;
		logic                         irq_n;
	} rfph_top_st_t;

	rfph_top_st_t                 q;
	rfph_top_st_t                 d;
	logic                         tx_push;
	logic                         tx_pop;
	logic [7:0]                   tx_rdata;
	logic                         tx_empty;
	logic [rfph_pkg::CNT_W-1:0]   tx_count;
	logic                         rx_push;
	logic                         rx_pop;
	logic [7:0]                   rx_rdata;
	logic [rfph_pkg::CNT_W-1:0]   rx_count;
	logic [7:0]                   tx_crc_byte;
	logic [15:0]                  tx_crc_nx;
	logic [15:0]                  rx_crc_nx;
	logic                         tbit;
	logic                         rx_bit_v;
	logic                         rx_raw;
	logic                         rx_bit;
	logic [7:0]                   rx_byte;
	logic                         in_bytes;
	logic                         byte_done;
	logic [5:0]                   pc;
	logic                         ld;
	logic [7:0]                   ld_byte;
	logic                         ld_whit;
	logic                         start_b;
	logic                         rehunt;
	logic [rfph_pkg::IRQ_W-1:0]   ev;

	function automatic logic [8:0] rfph_pn_step(input logic [8:0] pn);
		return {pn[0] ^ pn[rfph_pkg::PN9_TAP], pn[8:1]};
	endfunction

	// ****************************************
	// Queues and CRC
	// ****************************************
	assign tx_push = cmd_i.valid && (cmd_i.code == rfph_pkg::CMD_TX_LOAD);
	assign rx_pop  = cmd_i.valid && (cmd_i.code == rfph_pkg::CMD_RX_READ);

	// Full writes and empty reads are absorbed inside the queue
	rfph_fifo #(.WIDTH(8), .DEPTH(rfph_pkg::FIFO_DEPTH)) u_tx_fifo (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.clr_i     (fifo_clr_i[rfph_pkg::CLR_TX]),
		.push_i    (tx_push),
		.wdata_i   (cmd_i.wdata),
		.pop_i     (tx_pop),
		.rdata_o   (tx_rdata),
		.count_o   (tx_count),
		.full_o    (),
		.empty_o   (tx_empty)
	);

	rfph_fifo #(.WIDTH(8), .DEPTH(rfph_pkg::FIFO_DEPTH)) u_rx_fifo (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.clr_i     (fifo_clr_i[rfph_pkg::CLR_RX]),
		.push_i    (rx_push),
		.wdata_i   (rx_byte),
		.pop_i     (rx_pop),
		.rdata_o   (rx_rdata),
		.count_o   (rx_count),
		.full_o    (),
		.empty_o   ()
	);

	assign tx_crc_byte = (q.txs == rfph_pkg::TX_HDR) ? cfg_i.hdr :
	                     (q.txs == rfph_pkg::TX_LEN) ? cfg_i.pay_len : tx_rdata;

	rfph_crc16 u_tx_crc (
		.crc_i  (q.tcrc),
		.byte_i (tx_crc_byte),
		.crc_o  (tx_crc_nx)
	);

	rfph_crc16 u_rx_crc (
		.crc_i  (q.rcrc),
		.byte_i (rx_byte),
		.crc_o  (rx_crc_nx)
	);

	// ****************************************
	// Bit paths
	// ****************************************
	assign tbit      = q.tsh[7] ^ (q.twhit & q.tpn[0]);
	// Manchester pairs are framed from the first chip after enable; no phase hunt
	assign rx_bit_v  = rx_chip_valid_i && (!cfg_i.manch || q.rhalf);
	assign rx_raw    = cfg_i.manch ? q.rfirst : rx_chip_i;
	assign rx_bit    = rx_raw ^ (q.rwhit & q.rpn[0]);
	assign rx_byte   = {q.rbyte[6:0], rx_bit};
	assign in_bytes  = (q.rxs == rfph_pkg::RX_HDR) || (q.rxs == rfph_pkg::RX_LEN) ||
	                   (q.rxs == rfph_pkg::RX_DATA) || (q.rxs == rfph_pkg::RX_CRC);
	assign byte_done = in_bytes && rx_bit_v && (q.rbits == 3'h7);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		d       = q;
		ev      = '0;
		tx_pop  = 1'b0;
		rx_push = 1'b0;
		ld      = 1'b0;
		ld_byte = 8'h00;
		ld_whit = 1'b0;
		start_b = 1'b0;
		rehunt  = 1'b0;
		pc      = (q.rprecnt != 6'h00 && rx_raw == q.rsr[0]) ? 6'h01 : q.rprecnt + 6'h01;
		d.chip_v = 1'b0;
		d.rd_v   = rx_pop;
		if (rx_pop) begin
			d.rd_data = rx_rdata;
		end

		// Transmit serializer drains a byte before the next is loaded
		if (q.tbits != 4'h0) begin
			if (tx_chip_req_i) begin
				d.chip_v = 1'b1;
				d.chip   = (cfg_i.manch && q.thalf) ? ~tbit : tbit;
				if (cfg_i.manch && !q.thalf) begin
					d.thalf = 1'b1;
				end else begin
					d.thalf = 1'b0;
					d.tsh   = {q.tsh[6:0], 1'b0};
					d.tbits = q.tbits - 4'h1;
					if (q.twhit) begin
						d.tpn = rfph_pn_step(q.tpn);
					end
				end
			end
		end else begin
			case (q.txs)
				rfph_pkg::TX_IDLE: begin
					if (tx_start_i) begin
						d.txs  = rfph_pkg::TX_PRE;
						d.tcnt = 8'h00;
						d.tcrc = rfph_pkg::CRC_INIT;
						d.tpn  = rfph_pkg::PN9_SEED;
					end
				end
				rfph_pkg::TX_PRE: begin
					if (!cfg_i.ph_tx_en || !cfg_i.fld.pre) begin
						d.txs = rfph_pkg::TX_SYNC;
					end else begin
						ld      = 1'b1;
						ld_byte = rfph_pkg::PRE_PATTERN;
						d.tcnt  = q.tcnt + 8'h01;
						if (q.tcnt + 8'h01 >= {4'h0, cfg_i.pre_len}) begin
							d.txs  = rfph_pkg::TX_SYNC;
							d.tcnt = 8'h00;
						end
					end
				end
				rfph_pkg::TX_SYNC: begin
					if (!cfg_i.ph_tx_en || !cfg_i.fld.sync) begin
						d.txs = rfph_pkg::TX_HDR;
					end else begin
						ld      = 1'b1;
						ld_byte = q.tcnt[0] ? cfg_i.sync_word[7:0] : cfg_i.sync_word[15:8];
						d.tcnt  = q.tcnt[0] ? 8'h00 : 8'h01;
						if (q.tcnt[0]) begin
							d.txs = rfph_pkg::TX_HDR;
						end
					end
				end
				rfph_pkg::TX_HDR: begin
					d.txs = rfph_pkg::TX_LEN;
					if (cfg_i.ph_tx_en && cfg_i.fld.hdr) begin
						ld      = 1'b1;
						ld_whit = cfg_i.whiten;
						ld_byte = cfg_i.hdr;
						d.tcrc  = tx_crc_nx;
					end
				end
				rfph_pkg::TX_LEN: begin
					d.txs = rfph_pkg::TX_DATA;
					if (cfg_i.ph_tx_en && cfg_i.fld.len) begin
						ld      = 1'b1;
						ld_whit = cfg_i.whiten;
						ld_byte = cfg_i.pay_len;
						d.tcrc  = tx_crc_nx;
					end
				end
				rfph_pkg::TX_DATA: begin
					if (q.tcnt == cfg_i.pay_len) begin
						d.txs  = rfph_pkg::TX_CRC;
						d.tcnt = 8'h00;
					end else if (!tx_empty) begin
						tx_pop  = 1'b1;
						ld      = 1'b1;
						ld_whit = cfg_i.whiten;
						ld_byte = tx_rdata;
						d.tcrc  = tx_crc_nx;
						d.tcnt  = q.tcnt + 8'h01;
					end else if (!cfg_i.ph_tx_en) begin
						d.txs = rfph_pkg::TX_DONE;
					end
				end
				rfph_pkg::TX_CRC: begin
					if (!cfg_i.ph_tx_en || !cfg_i.fld.crc) begin
						d.txs = rfph_pkg::TX_DONE;
					end else begin
						ld      = 1'b1;
						ld_whit = cfg_i.whiten;
						ld_byte = q.tcnt[0] ? q.tcrc[7:0] : q.tcrc[15:8];
						d.tcnt  = q.tcnt[0] ? 8'h00 : 8'h01;
						if (q.tcnt[0]) begin
							d.txs = rfph_pkg::TX_DONE;
						end
					end
				end
				rfph_pkg::TX_DONE: begin
					ev[rfph_pkg::IRQ_TX_DONE] = 1'b1;
					d.txs = rfph_pkg::TX_IDLE;
				end
				default: begin
					d.txs = rfph_pkg::TX_IDLE;
				end
			endcase
		end
		if (ld) begin
			d.tsh   = ld_byte;
			d.tbits = rfph_pkg::BYTE_BITS;
			d.twhit = ld_whit;
		end
		d.busy = (d.txs != rfph_pkg::TX_IDLE);

		// Receive chip pairing
		if (rx_chip_valid_i && cfg_i.manch) begin
			d.rhalf  = !q.rhalf;
			d.rfirst = rx_chip_i;
		end
		if (in_bytes && rx_bit_v) begin
			d.rbyte = rx_byte;
			d.rbits = q.rbits + 3'h1;
			if (q.rwhit) begin
				d.rpn = rfph_pn_step(q.rpn);
			end
		end

		if (!rx_on_i) begin
			d.rxs   = rfph_pkg::RX_OFF;
			d.rhalf = 1'b0;
		end else begin
			case (q.rxs)
				rfph_pkg::RX_OFF: begin
					rehunt = 1'b1;
				end
				rfph_pkg::RX_PRE: begin
					if (!cfg_i.ph_rx_en || !cfg_i.fld.pre) begin
						d.rxs = rfph_pkg::RX_SYNC;
					end else if (rx_bit_v) begin
						d.rsr     = {q.rsr[14:0], rx_raw};
						d.rprecnt = pc;
						if (pc >= cfg_i.pre_thresh) begin
							ev[rfph_pkg::IRQ_PRE] = 1'b1;
							d.rxs = rfph_pkg::RX_SYNC;
						end
					end
				end
				rfph_pkg::RX_SYNC: begin
					if (!cfg_i.ph_rx_en || !cfg_i.fld.sync) begin
						start_b = 1'b1;
					end else if (rx_bit_v) begin
						d.rsr = {q.rsr[14:0], rx_raw};
						if ({q.rsr[14:0], rx_raw} == cfg_i.sync_word) begin
							ev[rfph_pkg::IRQ_SYNC] = 1'b1;
							start_b = 1'b1;
						end
					end
				end
				rfph_pkg::RX_HDR: begin
					if (!cfg_i.ph_rx_en || !cfg_i.fld.hdr) begin
						d.rxs = rfph_pkg::RX_LEN;
					end else if (byte_done) begin
						if (rx_byte != cfg_i.hdr) begin
							rehunt = 1'b1;
						end else begin
							d.rcrc = rx_crc_nx;
							d.rxs  = rfph_pkg::RX_LEN;
						end
					end
				end
				rfph_pkg::RX_LEN: begin
					if (!cfg_i.ph_rx_en || !cfg_i.fld.len) begin
						d.rlen = cfg_i.pay_len;
						d.rxs  = rfph_pkg::RX_DATA;
					end else if (byte_done) begin
						d.rlen = rx_byte;
						d.rcrc = rx_crc_nx;
						d.rxs  = rfph_pkg::RX_DATA;
					end
				end
				rfph_pkg::RX_DATA: begin
					if (q.rcnt == q.rlen) begin
						d.rxs  = rfph_pkg::RX_CRC;
						d.rcnt = 8'h00;
					end else if (byte_done) begin
						rx_push = 1'b1;
						d.rcrc  = rx_crc_nx;
						d.rcnt  = q.rcnt + 8'h01;
					end
				end
				rfph_pkg::RX_CRC: begin
					if (!cfg_i.ph_rx_en || !cfg_i.fld.crc) begin
						ev[rfph_pkg::IRQ_PKT] = 1'b1;
						rehunt = 1'b1;
					end else if (byte_done) begin
						if (!q.rcnt[0]) begin
							d.rchi = rx_byte;
							d.rcnt = 8'h01;
						end else begin
							ev[rfph_pkg::IRQ_PKT] = ({q.rchi, rx_byte} == q.rcrc);
							ev[rfph_pkg::IRQ_CRC] = ({q.rchi, rx_byte} != q.rcrc);
							rehunt = 1'b1;
						end
					end
				end
				default: begin
					d.rxs = rfph_pkg::RX_OFF;
				end
			endcase
		end
		if (rehunt) begin
			d.rxs     = rfph_pkg::RX_PRE;
			d.rprecnt = 6'h00;
		end
		if (start_b) begin
			d.rxs   = rfph_pkg::RX_HDR;
			d.rbits = 3'h0;
			d.rcnt  = 8'h00;
			d.rpn   = rfph_pkg::PN9_SEED;
			d.rwhit = cfg_i.whiten;
			d.rcrc  = rfph_pkg::CRC_INIT;
		end

		// Queue level crossings, judged on registered counts
		d.txc_prev = tx_count;
		d.rxc_prev = rx_count;
		ev[rfph_pkg::IRQ_TX_AE] = (q.txc_prev > cfg_i.tx_ae_level) && (tx_count == cfg_i.tx_ae_level);
		ev[rfph_pkg::IRQ_RX_AF] = (q.rxc_prev < cfg_i.rx_af_level) && (rx_count >= cfg_i.rx_af_level);

		// A new event outranks an acknowledge in the same cycle
		d.ev    = ev;
		d.irq   = (q.irq & ~irq_ack_i) | ev;
		d.irq_n = ~|(d.irq & irq_en_i);
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			q       <= '0;
			q.txs   <= rfph_pkg::TX_IDLE;
			q.rxs   <= rfph_pkg::RX_OFF;
			q.irq_n <= rfph_pkg::IRQ_N_RST;
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign rd_data_o             = q.rd_data;
	assign rd_valid_o            = q.rd_v;
	assign tx_chip_o             = q.chip;
	assign tx_chip_valid_o       = q.chip_v;
	assign tx_busy_o             = q.busy;
	assign pre_ok_o              = q.ev[rfph_pkg::IRQ_PRE];
	assign sync_found_o          = q.ev[rfph_pkg::IRQ_SYNC];
	assign frame_accepted_o      = q.ev[rfph_pkg::IRQ_PKT];
	assign crc_mismatch_o        = q.ev[rfph_pkg::IRQ_CRC];
	assign tx_frame_done_event_o = q.ev[rfph_pkg::IRQ_TX_DONE];
	assign tx_count_o            = tx_count;
	assign rx_count_o            = rx_count;
	assign irq_flags_o           = q.irq;
	assign host_irq_n_o          = q.irq_n;
endmodule

// File: tb/rfph_chk.sv
// Assertion checker bound to the packet handler top
`timescale 1ns/1ps
module rfph_chk (
	// Clock, reset and inputs
	input wire logic                clk_sys_i,
	input wire logic                rst_n_i,
	input wire rfph_pkg::rfph_cmd_t cmd_i,
	input wire logic [1:0]          fifo_clr_i,
	input wire rfph_pkg::rfph_cfg_t cfg_i,
	input wire logic [6:0]          irq_en_i,
	// Outputs
	input wire logic                rd_valid_o,
	input wire logic                pre_ok_o,
	input wire logic                sync_found_o,
	input wire logic                tx_busy_o,
	input wire logic                frame_accepted_o,
	input wire logic                crc_mismatch_o,
	input wire logic                tx_frame_done_event_o,
	input wire logic [6:0]          tx_count_o,
	input wire logic [6:0]          rx_count_o,
	input wire logic [6:0]          irq_flags_o,
	input wire logic                host_irq_n_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	property p_rd; cmd_i.valid && cmd_i.code == 8'h77 |=> rd_valid_o; endproperty
	a_rd: assert property (p_rd) else $error("read gave no strobe");
	property p_push; cmd_i.valid && cmd_i.code == 8'h66 && !tx_busy_o && fifo_clr_i == 2'h0 && tx_count_o < 7'h40
		|=> tx_count_o == $past(tx_count_o) + 7'h01; endproperty
	a_push: assert property (p_push) else $error("load not queued");
	property p_full; cmd_i.valid && !tx_busy_o && fifo_clr_i == 2'h0 && tx_count_o == 7'h40 |=> tx_count_o == 7'h40;
	endproperty
	a_full: assert property (p_full) else $error("full queue changed");
	// Clear wins over a same-cycle push, so the count must read zero
	property p_clr; fifo_clr_i != 2'h0 |=> ($past(fifo_clr_i[0]) ? tx_count_o == 7'h00 : 1'b1)
		&& ($past(fifo_clr_i[1]) ? rx_count_o == 7'h00 : 1'b1); endproperty
	a_clr: assert property (p_clr) else $error("clear left data");
	property p_irq; host_irq_n_o == !(|(irq_flags_o & $past(irq_en_i))); endproperty
	a_irq: assert property (p_irq) else $error("irq pin wrong");
	property p_mis; crc_mismatch_o |-> !frame_accepted_o; endproperty
	a_mis: assert property (p_mis) else $error("bad frame accepted");
	property p_done; tx_frame_done_event_o |-> !tx_busy_o; endproperty
	a_done: assert property (p_done) else $error("still busy after sent");
	property p_af; $rose(irq_flags_o[2]) |-> rx_count_o >= cfg_i.rx_af_level; endproperty
	a_af: assert property (p_af) else $error("almost full too early");
	property p_pre; pre_ok_o |-> irq_flags_o[3]; endproperty
	a_pre: assert property (p_pre) else $error("preamble flag not latched");
	property p_sync; sync_found_o |-> irq_flags_o[4] && !pre_ok_o; endproperty
	a_sync: assert property (p_sync) else $error("sync flag not latched");
endmodule
bind rfph_top rfph_chk rfph_chk_i (.clk_sys_i, .rst_n_i, .cmd_i, .fifo_clr_i, .cfg_i, .irq_en_i, .rd_valid_o,
	.pre_ok_o, .sync_found_o,
	.tx_busy_o, .frame_accepted_o, .crc_mismatch_o, .tx_frame_done_event_o, .tx_count_o, .rx_count_o,
	.irq_flags_o, .host_irq_n_o);

// File: tb/rfph_host.sv
// Host model issuing queue commands
`timescale 1ns/1ps
module rfph_host (
	// Clock
	input  wire logic          clk_sys_i,
	// Command port
	output rfph_pkg::rfph_cmd_t cmd_o
);
	initial cmd_o = '0;
	// Valid stands for exactly one edge, so each command is taken once
	task automatic send(input logic [7:0] c, input logic [7:0] d);
		@(posedge clk_sys_i) #1;
		cmd_o = '{1'b1, c, d};
		@(posedge clk_sys_i) #1;
		cmd_o.valid = 1'b0;
	endtask
endmodule

// File: tb/tb_rfph_top.sv
// Self-checking bench: transmit frames looped back into the receiver
`timescale 1ns/1ps
module tb_rfph_top;
	logic                clk_sys_i = 1'b0, rst_n_i = 1'b0, tx_start_i = 1'b0, rx_on_i = 1'b0;
	logic                req = 1'b0, rxv = 1'b0, rxc = 1'b0;
	logic [1:0]          clr = 2'h0;
	logic [6:0]          ack = 7'h00, en = 7'h7f, txc, rxn, flags;
	logic [7:0]          rd_data_o, b;
	logic                rd_valid_o, tx_chip_o, tx_chip_valid_o, acc, mis, irq_n;
	rfph_pkg::rfph_cmd_t cmd;
	rfph_pkg::rfph_cfg_t cfg;
	int                  seed = 32'hd434414b, miscompares = 0, n_checks = 0, nchip = 0, flip = -1, ph = 0, i;
	logic [7:0]          exp_q[$];
	always #4 clk_sys_i = ~clk_sys_i;
	rfph_host rfph_host_i (.clk_sys_i, .cmd_o(cmd));
	rfph_top rfph_top_i (.clk_sys_i, .rst_n_i, .cmd_i(cmd), .fifo_clr_i(clr), .rd_data_o, .rd_valid_o, .cfg_i(cfg),
		.tx_start_i, .rx_on_i, .tx_chip_req_i(req), .tx_chip_o, .tx_chip_valid_o, .tx_busy_o(), .rx_chip_valid_i(rxv),
		.rx_chip_i(rxc), .pre_ok_o(), .sync_found_o(), .frame_accepted_o(acc), .crc_mismatch_o(mis),
		.tx_frame_done_event_o(), .tx_count_o(txc), .rx_count_o(rxn), .irq_en_i(en), .irq_ack_i(ack),
		.irq_flags_o(flags), .host_irq_n_o(irq_n));
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic end_sim;
		chk("exp_left", 8'h00, 8'(exp_q.size()));
		if (miscompares == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Modem: one chip request every 8 cycles, chips fed straight back, one may be flipped
	always @(posedge clk_sys_i) begin
		#1;
		ph++;
		req = ph[2:0] == 3'h0;
		rxv = tx_chip_valid_o;
		rxc = tx_chip_o ^ (nchip == flip);
		if (tx_chip_valid_o) nchip++;
	end
	// A read strobe with no note waiting is itself a mismatch
	always @(posedge clk_sys_i) #1 if (rd_valid_o === 1'b1) begin
		if (exp_q.size() == 0) chk("rd_extra", 8'h00, 8'h01);
		else chk("rd_data", exp_q.pop_front(), rd_data_o);
	end
	task automatic frame(input logic w, input int f, input logic ok);
		cfg.whiten = w;
		cfg.manch = w;
		rx_on_i = 1'b0;
		@(posedge clk_sys_i) #1 rx_on_i = 1'b1;
		for (i = 0; i < 4; i++) begin
			b = $random(seed);
			if (ok) exp_q.push_back(b);
			rfph_host_i.send(8'h66, b);
		end
		nchip = 0;
		flip = f;
		@(posedge clk_sys_i) #1 tx_start_i = 1'b1;
		@(posedge clk_sys_i) #1 tx_start_i = 1'b0;
		for (i = 0; i < 6000 && (acc | mis) !== 1'b1; i++) @(posedge clk_sys_i) #1;
		chk("accepted", ok, acc);
		chk("crc_err", !ok, mis);
	endtask
	task automatic flags_chk(input logic [6:0] e);
		repeat (4) @(posedge clk_sys_i);
		#1 chk("flags", e, flags);
		chk("irq_n", 0, irq_n);
		// Masking every flag must release the pin while the flags stay latched
		en = 7'h00;
		@(posedge clk_sys_i) #1 chk("irq_n_mask", 1, irq_n);
		en = 7'h7f;
		ack = 7'h7f;
		@(posedge clk_sys_i) #1 ack = 7'h00;
		@(posedge clk_sys_i) #1 chk("irq_n", 1, irq_n);
	endtask
	initial begin
		cfg = '{1'b1, 1'b1, 5'h1f, 1'b0, 1'b0, 4'h4, 6'h10, 16'h2dd4, 8'h5a, 8'h04, 7'h02, 7'h04};
		repeat (10) @(posedge clk_sys_i);
		#1 rst_n_i = 1'b1;
		chk("irq_n", 1, irq_n);
		frame(1'b0, -1, 1'b1);
		flags_chk(7'h3f);
		for (int j = 0; j < 4; j++) rfph_host_i.send(8'h77, 8'h00);
		repeat (3) @(posedge clk_sys_i) #1;
		chk("rx_count", 0, rxn);
		// Whitened Manchester frame with a data chip flipped
		frame(1'b1, 140, 1'b0);
		flags_chk(7'h5f);
		clr = 2'h2;
		@(posedge clk_sys_i) #1 clr = 2'h0;
		@(posedge clk_sys_i) #1 chk("rx_count", 0, rxn);
		for (int j = 0; j < 65; j++) rfph_host_i.send(8'h66, $random(seed));
		chk("tx_count", 7'h40, txc);
		clr = 2'h1;
		@(posedge clk_sys_i) #1 clr = 2'h0;
		@(posedge clk_sys_i) #1 chk("tx_count", 0, txc);
		// No header or length field; the receiver falls back on the set payload length
		cfg.fld = 5'h19;
		frame(1'b0, -1, 1'b1);
		flags_chk(7'h3f);
		for (int j = 0; j < 4; j++) rfph_host_i.send(8'h77, 8'h00);
		repeat (3) @(posedge clk_sys_i) #1;
		chk("rx_count", 0, rxn);
		end_sim;
	end
	initial begin
		#400000;
		miscompares++;
		end_sim;
	end
endmodule
